/* lcdsd_com_scan.sv */
`timescale 1ns/100ps
`default_nettype none

// common slot sequencer driven by oscillator ticks
module lcdsd_com_scan (
    input wire logic coreClk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic oscTick,
    input wire logic runEn,
    input wire logic [1:0] frameSel,
    input wire logic [3:0] comCount,
    output logic [2:0] activeCom
);

    typedef struct packed {
        logic [lcdsd_pkg::SLOT_CNT_W-1:0] divCnt;
        logic [2:0] com;
    } lcdsd_scan_state_type;

    lcdsd_scan_state_type s_q;
    lcdsd_scan_state_type s_d;

    // slot length in ticks from source divider and duty [RULE10] [RULE11]
    function automatic logic [lcdsd_pkg::SLOT_CNT_W-1:0] slotLen(
        input logic [1:0] sel,
        input logic [3:0] coms
    );
        int div;
        int sh;
        div = lcdsd_pkg::SRC_DIV_32HZ;
        if (sel == lcdsd_pkg::FRAME_SEL_21HZ) begin
            div = lcdsd_pkg::SRC_DIV_21HZ;
        end else if (sel == lcdsd_pkg::FRAME_SEL_16HZ) begin
            div = lcdsd_pkg::SRC_DIV_16HZ;
        end
        sh = (int'(coms) >= lcdsd_pkg::HIGH_DUTY_MIN) ?
            lcdsd_pkg::SLOT_SHIFT_HIGH : lcdsd_pkg::SLOT_SHIFT_LOW;
        return lcdsd_pkg::SLOT_CNT_W'(div >> sh);
    endfunction

    // ascending one-per-slot scan, wrap after last used common [RULE18]
    always_comb begin
        s_d = s_q;
        if (!runEn) begin
            // restart at common 0 whenever the display is off [RULE12]
            s_d = '0;
        end else if (oscTick && frameSel != 2'h3) begin
            if (s_q.divCnt >= slotLen(frameSel, comCount) - 1'b1) begin
                s_d.divCnt = '0;
                if ({1'b0, s_q.com} >= comCount - 4'h1) begin
                    s_d.com = '0;
                end else begin
                    s_d.com = s_q.com + 3'h1;
                end
            end else begin
                s_d.divCnt = s_q.divCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge coreClk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign activeCom = s_q.com;

endmodule
`default_nettype wire

/* lcdsd_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// panel: last row lit per common
// ------------------------------------------------------------------
module lcdsd_panel_model (
    input wire logic core_clk,
    input wire logic [55:0] segIn,
    input wire logic [7:0] comIn,
    output logic [55:0] litRow [8]
);
    // plain segment levels only
    always @(posedge core_clk) begin
        for (int c = 0; c < 8; c++) begin
            if (comIn == (8'h01 << c)) litRow[c] <= segIn;
        end
    end
endmodule

`default_nettype wire

/* lcdsd_pkg.sv */
package lcdsd_pkg;

    // ------------------------------------------------------------------
    // panel geometry
    // ------------------------------------------------------------------
    localparam int SEG_NUM = 56;
    localparam int COM_NUM = 8;
    localparam int DMEM_WORDS = 128;
    localparam int DMEM_BITS = 4;
    localparam int MAP_WORDS = SEG_NUM * COM_NUM;

    // ------------------------------------------------------------------
    // apb byte addresses
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DMEM_BASE = 12'h400;
    localparam logic [11:0] ADDR_DMEM_LAST = 12'h5FC;
    localparam logic [11:0] ADDR_MAP_BASE = 12'h800;
    localparam logic [11:0] ADDR_MAP_LAST = 12'hEFC;
    // cpu data addresses of the display memory window
    localparam logic [15:0] DMEM_CPU_FIRST = 16'hF000;
    localparam logic [15:0] DMEM_CPU_LAST = 16'hF07F;

    // ------------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_DUTY_LSB = 3;
    localparam int CTRL_STATIC_BIT = 6;
    localparam int CTRL_FRAME_LSB = 7;
    localparam logic POWER_RESET = 1'b0;
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam logic [2:0] DUTY_RESET = 3'h0;
    localparam logic STATIC_RESET = 1'b0;
    localparam logic [1:0] FRAME_RESET = 2'h0;

    // display mode codes; 1 and 3 both mean all-on
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ALL_OFF = 2'h2;

    // frame clock source codes; 3 is prohibited
    localparam logic [1:0] FRAME_SEL_32HZ = 2'h0;
    localparam logic [1:0] FRAME_SEL_21HZ = 2'h1;
    localparam logic [1:0] FRAME_SEL_16HZ = 2'h2;

    // status register fields
    localparam int STATUS_COM_LSB = 0;
    localparam int STATUS_RUN_BIT = 3;

    // ------------------------------------------------------------------
    // segment map entry layout
    // ------------------------------------------------------------------
    localparam int MAP_ENTRY_W = 9;
    localparam int MAP_BIT_LSB = 0;
    localparam int MAP_LO_LSB = 2;
    localparam int MAP_HI_LSB = 6;

    // ------------------------------------------------------------------
    // frame timing, counted in low speed oscillator ticks
    // ------------------------------------------------------------------
    localparam int OSC_HZ = 32768;
    localparam int SRC_DIV_32HZ = OSC_HZ / 32;
    localparam int SRC_DIV_21HZ = SRC_DIV_32HZ * 3 / 2;
    localparam int SRC_DIV_16HZ = OSC_HZ / 16;
    // high duties run 8 slots per source period, low duties 4
    localparam int SLOT_SHIFT_HIGH = 3;
    localparam int SLOT_SHIFT_LOW = 2;
    localparam int HIGH_DUTY_MIN = 6;
    localparam int SLOT_CNT_W = 10;

endpackage

/* lcdsd_seg_map.sv */
`timescale 1ns/100ps
`default_nettype none

// segment assignment table: one entry per segment and common position
module lcdsd_seg_map #(
    parameter int ENTRIES = lcdsd_pkg::MAP_WORDS,
    parameter int IDX_W = 9
) (
    input wire logic coreClk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [IDX_W-1:0] wrIdx,
    input wire logic [lcdsd_pkg::MAP_ENTRY_W-1:0] wrData,
    input wire logic [IDX_W-1:0] rdIdxA,
    output logic [lcdsd_pkg::MAP_ENTRY_W-1:0] rdDataA,
    input wire logic [IDX_W-1:0] rdIdxB,
    output logic [lcdsd_pkg::MAP_ENTRY_W-1:0] rdDataB
);

    generate
        if (ENTRIES > (1 << IDX_W)) begin : g_chk
            $error("seg map index too narrow");
        end
    endgenerate

    logic [lcdsd_pkg::MAP_ENTRY_W-1:0] table_q [ENTRIES];

    // table write; any memory nibble bit may go to any segment [RULE1] [RULE2]
    always_ff @(posedge coreClk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                table_q[i] <= '0;
            end
        end else if (clkEn && wrEn && (int'(wrIdx) < ENTRIES)) begin
            table_q[wrIdx] <= wrData;
        end
    end

    // two read ports: bus readback and image scan
    always_comb begin
        rdDataA = (int'(rdIdxA) < ENTRIES) ? table_q[rdIdxA] : '0;
        rdDataB = (int'(rdIdxB) < ENTRIES) ? table_q[rdIdxB] : '0;
    end

endmodule
`default_nettype wire

/* lcdsd_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // osc period in core cycles
    localparam int OSC_P = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic lowSpeedOscClock = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [55:0] segmentOutputs;
    logic [7:0] commonOutputs;
    logic [55:0] litRow [8];
    logic [1:0] oscDiv = 2'h0;
    logic [31:0] seed = 32'hDD69;
    int errCount = 0;
    int numChecks = 0;
    int dmem [128];
    int mapE [448];
    int mode = 2;
    int stat = 0;

    // ------------------------------------------------------------------
    // clocks, design and panel
    // ------------------------------------------------------------------
    always #20 core_clk = ~core_clk;

    // osc pin
    always @(posedge core_clk) begin
        oscDiv <= oscDiv + 2'h1;
        lowSpeedOscClock <= oscDiv[1];
    end

    lcdsd_top dut (
        .core_clk(core_clk), .arst_n(arst_n), .coreClkEn(1'b1),
        .lowSpeedOscClock(lowSpeedOscClock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .segmentOutputs(segmentOutputs),
        .commonOutputs(commonOutputs)
    );

    lcdsd_panel_model panel (
        .core_clk(core_clk), .segIn(segmentOutputs), .comIn(commonOutputs), .litRow(litRow)
    );

    // ------------------------------------------------------------------
    // tasks and reference model
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [63:0] got, input logic [63:0] exp, input string what);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("Error %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // apb transfer held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chkVal(n < 20, 1, "bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input int d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, 32'(d), r, e);
        chkVal(e, 0, "write refused");
    endtask

    task automatic setCtrl(input int m, input int duty, input int st, input int fr);
        logic [31:0] r;
        logic e;
        wr(lcdsd_pkg::ADDR_CTRL, 0); // off first
        mode = m;
        stat = st;
        wr(lcdsd_pkg::ADDR_CTRL, 1 | m << 1 | duty << 3 | st << 6 | fr << 7);
        apb(1'b0, lcdsd_pkg::ADDR_STATUS, 32'h0, r, e);
        chkVal(r[3], 1, "power status");
    endtask

    // expected row; static ors all eight
    function automatic logic [55:0] expSeg(input int c);
        logic [55:0] r;
        int e;
        r = '0;
        for (int s = 0; s < 56; s++) begin
            for (int k = 0; k < 8; k++) begin
                e = mapE[s * 8 + k];
                if ((stat != 0 || k == c) && dmem[e >> 2][e & 3]) r[s] = 1'b1;
            end
        end
        if (mode == 2) r = '0;
        else if (mode != 0) r = '1;
        return r;
    endfunction

    // times slots after the first, then compares panel rows if a whole frame ran
    task automatic checkFrame(input int n, input int fr, input int slots);
        int lim;
        int len;
        logic [7:0] prev;
        len = ((fr == 0) ? 1024 : (fr == 1) ? 1536 : 2048) >> ((n > 5) ? 3 : 2);
        lim = 0;
        while (commonOutputs !== 8'h01 && lim < 200) begin
            @(posedge core_clk);
            lim++;
        end
        for (int k = 1; k <= slots; k++) begin
            prev = commonOutputs;
            lim = 0;
            while (commonOutputs === prev && lim < 10000) begin
                @(posedge core_clk);
                lim++;
            end
            chkVal(commonOutputs, 8'h01 << (k % n), "common slot");
            if (k > 1) chkVal(lim, len * OSC_P, "slot length");
        end
        if (slots > n) begin
            for (int c = 0; c < n; c++) chkVal(litRow[c], expSeg(c), "row");
        end
        repeat (12) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios and watchdog
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        int x;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(1'b0, lcdsd_pkg::ADDR_CTRL, 32'h0, r, e);
        chkVal(r, 32'h4, "ctrl reset");
        apb(1'b0, 12'h100, 32'h0, r, e);
        chkVal({e, r}, 33'h100000000, "unmapped read");
        apb(1'b1, 12'h402, 32'h5, r, e);
        chkVal(e, 1, "misaligned write");
        $display("test reset done");
        for (int i = 0; i < 128; i++) begin
            dmem[i] = rnd() & 15;
            wr(lcdsd_pkg::ADDR_DMEM_BASE + 12'(i * 4), dmem[i]);
        end
        for (int i = 0; i < 448; i++) begin
            mapE[i] = rnd() & 511;
            wr(lcdsd_pkg::ADDR_MAP_BASE + 12'(i * 4), mapE[i]);
        end
        apb(1'b0, lcdsd_pkg::ADDR_DMEM_BASE + 12'h014, 32'h0, r, e);
        chkVal(r, dmem[5], "memory readback");
        for (int d = 0; d < 8; d++) begin
            x = (d < 4) ? d + 3 : ((d % 2 == 1) ? 8 : 7);
            setCtrl(0, d, 0, 0);
            checkFrame(x, 0, x + 1);
            $display("test duty %0d done", d);
        end
        // modes 1-3, then normal: memory untouched
        for (int m = 1; m <= 4; m++) begin
            setCtrl(m & 3, 0, 0, 0);
            checkFrame(3, 0, 4);
        end
        $display("test modes done");
        for (int f = 1; f <= 2; f++) begin
            setCtrl(0, 0, 0, f);
            checkFrame(3, f, 2);
        end
        $display("test frame sources done");
        for (int s = 0; s < 56; s++) begin
            x = rnd() & 511;
            for (int c = 0; c < 8; c++) begin
                mapE[s * 8 + c] = x; // same entry per common
                wr(lcdsd_pkg::ADDR_MAP_BASE + 12'((s * 8 + c) * 4), x);
            end
        end
        setCtrl(0, 2, 1, 0);
        repeat (500) @(posedge core_clk);
        chkVal(commonOutputs, 8'hFF, "static commons");
        chkVal(segmentOutputs, expSeg(0), "static segments");
        wr(lcdsd_pkg::ADDR_CTRL, 0);
        repeat (4) @(posedge core_clk);
        chkVal({commonOutputs, segmentOutputs}, 0, "display off");
        $display("test static and off done");
        conclude();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        errCount++;
        $display("Error %0t: timeout", $time);
        conclude();
    end
endmodule

`default_nettype wire

/* lcdsd_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1: any memory bit to any segment 0-55
// RULE2: map entry holds high digit, low digit, bit
// RULE3: segment pins configured as plain lcd outputs
// RULE4: display power bit separate from mode
// RULE5: mode 0 normal, 1/3 all-on, 2 all-off
// RULE6: normal mode passes memory bits unchanged
// RULE7: all-on drives every segment, memory untouched
// RULE8: all-off drives nothing, reset default mode; code blanks the segments only, commons keep scanning
// RULE9: duty code picks 3 to 8 commons
// RULE10: frame source 32, 21.3, 16 Hz; 3 prohibited
// RULE11: frame rate source times 8/n or 4/n
// RULE12: software turns display off before source change
// RULE13: static bit selects static drive
// RULE14: static segment on if any common bit set
// RULE15: static drive uses all eight commons
// RULE16: software writes equal bits per static segment
// RULE17: display memory nibbles, one means segment on
// RULE18: commons scanned ascending, segment shows matching bit
module lcdsd_top #(
    parameter int SEG_COUNT = lcdsd_pkg::SEG_NUM,
    parameter int COM_COUNT = lcdsd_pkg::COM_NUM
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic coreClkEn,
    input wire logic lowSpeedOscClock,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcdsd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [SEG_COUNT-1:0] segmentOutputs,
    output logic [COM_COUNT-1:0] commonOutputs
);

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    generate
        if (SEG_COUNT != lcdsd_pkg::SEG_NUM || COM_COUNT != lcdsd_pkg::COM_NUM) begin : g_chk
            $error("segment and common counts are fixed by the map layout");
        end
    endgenerate

    localparam int MAP_N = lcdsd_pkg::MAP_WORDS;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic power;
        logic [1:0] mode;
        logic [2:0] duty;
        logic staticDrv;
        logic [1:0] frameSel;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] oscSync;
        logic oscPrev;
        logic [8:0] scanIdx;
        logic [MAP_N-1:0] image;
        logic [lcdsd_pkg::SEG_NUM-1:0] segOut;
        logic [lcdsd_pkg::COM_NUM-1:0] comOut;
    } lcdsd_top_state_type;

    lcdsd_top_state_type r_q;
    lcdsd_top_state_type r_d;

    // display memory, left undefined at reset like ordinary data ram
    logic [lcdsd_pkg::DMEM_BITS-1:0] dmem_q [lcdsd_pkg::DMEM_WORDS];

    logic [lcdsd_pkg::MAP_ENTRY_W-1:0] mapRdBus;
    logic [lcdsd_pkg::MAP_ENTRY_W-1:0] mapRdScan;
    logic [2:0] activeCom;
    logic oscTick;
    logic setupPhase;
    logic writeStrobe;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic isDmem(input logic [lcdsd_pkg::ADDR_W-1:0] a);
        return (a >= lcdsd_pkg::ADDR_DMEM_BASE) && (a <= lcdsd_pkg::ADDR_DMEM_LAST)
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic isMap(input logic [lcdsd_pkg::ADDR_W-1:0] a);
        return (a >= lcdsd_pkg::ADDR_MAP_BASE) && (a <= lcdsd_pkg::ADDR_MAP_LAST)
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic isMapped(input logic [lcdsd_pkg::ADDR_W-1:0] a);
        return (a == lcdsd_pkg::ADDR_CTRL) || (a == lcdsd_pkg::ADDR_STATUS)
            || isDmem(a) || isMap(a);
    endfunction

    // duty code to number of commons in use [RULE9]
    function automatic logic [3:0] dutyComs(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h3;
        case (code)
            3'h0: n = 4'h3;
            3'h1: n = 4'h4;
            3'h2: n = 4'h5;
            3'h3: n = 4'h6;
            3'h4, 3'h6: n = 4'h7;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    lcdsd_seg_map #(
        .ENTRIES(MAP_N),
        .IDX_W(9)
    ) u_map (
        .coreClk(core_clk),
        .arst_n(arst_n),
        .clkEn(coreClkEn),
        .wrEn(writeStrobe && isMap(paddr)),
        .wrIdx(paddr[10:2]),
        .wrData(pwdata[lcdsd_pkg::MAP_ENTRY_W-1:0]),
        .rdIdxA(paddr[10:2]),
        .rdDataA(mapRdBus),
        .rdIdxB(r_q.scanIdx),
        .rdDataB(mapRdScan)
    );

    // static drive keeps the scan at eight slots [RULE15]
    lcdsd_com_scan u_scan (
        .coreClk(core_clk),
        .arst_n(arst_n),
        .clkEn(coreClkEn),
        .oscTick(oscTick),
        .runEn(r_q.power),
        .frameSel(r_q.frameSel),
        .comCount(r_q.staticDrv ? 4'h8 : dutyComs(r_q.duty)),
        .activeCom(activeCom)
    );

    // ------------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------------
    // one wait-free access cycle: pready rises in the first access cycle
    assign setupPhase = psel && !penable && !r_q.pready;
    assign writeStrobe = psel && penable && pwrite && r_q.pready && !r_q.pslverr;
    // second sync stage only feeds the edge detector
    assign oscTick = r_q.oscSync[1] && !r_q.oscPrev;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [lcdsd_pkg::MAP_ENTRY_W-1:0] ent;
        logic [6:0] wordIdx;
        logic [3:0] nib;
        logic [3:0] comsUsed;
        r_d = r_q;
        ent = mapRdScan;
        wordIdx = {ent[lcdsd_pkg::MAP_HI_LSB +: 3], ent[lcdsd_pkg::MAP_LO_LSB +: 4]};
        nib = dmem_q[wordIdx];
        comsUsed = dutyComs(r_q.duty);

        // oscillator pin synchroniser and edge history
        r_d.oscSync = {r_q.oscSync[0], lowSpeedOscClock};
        r_d.oscPrev = r_q.oscSync[1];

        // apb answer registered one cycle after setup
        r_d.pready = setupPhase;
        r_d.pslverr = setupPhase && !isMapped(paddr);
        if (setupPhase) begin
            r_d.prdata = 32'h0000_0000;
            if (paddr == lcdsd_pkg::ADDR_CTRL) begin
                r_d.prdata[lcdsd_pkg::CTRL_POWER_BIT] = r_q.power;
                r_d.prdata[lcdsd_pkg::CTRL_MODE_LSB +: 2] = r_q.mode;
                r_d.prdata[lcdsd_pkg::CTRL_DUTY_LSB +: 3] = r_q.duty;
                r_d.prdata[lcdsd_pkg::CTRL_STATIC_BIT] = r_q.staticDrv;
                r_d.prdata[lcdsd_pkg::CTRL_FRAME_LSB +: 2] = r_q.frameSel;
            end else if (paddr == lcdsd_pkg::ADDR_STATUS) begin
                r_d.prdata[lcdsd_pkg::STATUS_COM_LSB +: 3] = activeCom;
                r_d.prdata[lcdsd_pkg::STATUS_RUN_BIT] = r_q.power;
            end else if (isDmem(paddr)) begin
                r_d.prdata[lcdsd_pkg::DMEM_BITS-1:0] = dmem_q[paddr[8:2]];
            end else if (isMap(paddr)) begin
                r_d.prdata[lcdsd_pkg::MAP_ENTRY_W-1:0] = mapRdBus;
            end
        end

        // control register write
        if (writeStrobe && paddr == lcdsd_pkg::ADDR_CTRL) begin
            r_d.power = pwdata[lcdsd_pkg::CTRL_POWER_BIT]; // [RULE4]
            r_d.mode = pwdata[lcdsd_pkg::CTRL_MODE_LSB +: 2];
            r_d.duty = pwdata[lcdsd_pkg::CTRL_DUTY_LSB +: 3];
            r_d.staticDrv = pwdata[lcdsd_pkg::CTRL_STATIC_BIT]; // [RULE13]
            r_d.frameSel = pwdata[lcdsd_pkg::CTRL_FRAME_LSB +: 2];
        end

        // refresh one image bit per cycle from map and memory [RULE1] [RULE2]
        r_d.image[r_q.scanIdx] = nib[ent[lcdsd_pkg::MAP_BIT_LSB +: 2]];
        if (int'(r_q.scanIdx) >= MAP_N - 1) begin
            r_d.scanIdx = '0;
        end else begin
            r_d.scanIdx = r_q.scanIdx + 9'h001;
        end

        // common drive: one slot active, all eight in static
        r_d.comOut = '0;
        if (r_q.power) begin
            if (r_q.staticDrv) begin
                r_d.comOut = '1; // [RULE15]
            end else if ({1'b0, activeCom} < comsUsed) begin
                r_d.comOut[activeCom] = 1'b1; // [RULE18] [RULE9]
            end
        end

        // segment drive per display mode
        for (int s = 0; s < lcdsd_pkg::SEG_NUM; s++) begin
            if (!r_q.power) begin
                r_d.segOut[s] = 1'b0;
            end else if (r_q.mode == lcdsd_pkg::MODE_ALL_OFF) begin
                r_d.segOut[s] = 1'b0; // [RULE8] [RULE5]
            end else if (r_q.mode != lcdsd_pkg::MODE_NORMAL) begin
                r_d.segOut[s] = 1'b1; // [RULE7] [RULE5]
            end else if (r_q.staticDrv) begin
                // any set common bit lights it [RULE14] [RULE16]
                r_d.segOut[s] = |r_q.image[s*lcdsd_pkg::COM_NUM +: lcdsd_pkg::COM_NUM];
            end else begin
                // bit of the active common, unaltered [RULE6] [RULE18] [RULE17]
                r_d.segOut[s] = r_q.image[s*lcdsd_pkg::COM_NUM + int'(activeCom)];
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // modes never touch memory; only bus writes reach it [RULE7] [RULE8]
    always_ff @(posedge core_clk) begin
        if (coreClkEn && writeStrobe && isDmem(paddr)) begin
            dmem_q[paddr[8:2]] <= pwdata[lcdsd_pkg::DMEM_BITS-1:0]; // [RULE17]
        end
    end

    // all-off is the reset mode [RULE8]
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '0;
            r_q.power <= lcdsd_pkg::POWER_RESET;
            r_q.mode <= lcdsd_pkg::MODE_RESET;
            r_q.duty <= lcdsd_pkg::DUTY_RESET;
            r_q.staticDrv <= lcdsd_pkg::STATIC_RESET;
            r_q.frameSel <= lcdsd_pkg::FRAME_RESET;
        end else if (coreClkEn) begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------------
    assign prdata = r_q.prdata;
    assign pready = r_q.pready;
    assign pslverr = r_q.pslverr;
    assign segmentOutputs = r_q.segOut;
    assign commonOutputs = r_q.comOut;

endmodule
`default_nettype wire

/* lcdsd_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// bus and scan checks
// ------------------------------------------------------------------
module lcdsd_top_asserts #(
    parameter int SEG_COUNT = 56,
    parameter int COM_COUNT = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [SEG_COUNT-1:0] segmentOutputs,
    input wire logic [COM_COUNT-1:0] commonOutputs
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // setup cycle; step between active commons
    sequence apbSetup;
        psel && !penable && !pready;
    endsequence
    sequence slotMove;
        $changed(commonOutputs) && $onehot(commonOutputs) && $onehot($past(commonOutputs));
    endsequence
    // ascending; wrap needs three commons
    property scanStep;
        slotMove |-> (commonOutputs == ($past(commonOutputs) << 1))
            || (commonOutputs == COM_COUNT'(1) && $past(commonOutputs) >= COM_COUNT'(4));
    endproperty
    // a slot outlasts eight core cycles
    property slotHold;
        ($changed(commonOutputs) && $onehot(commonOutputs)) |=> $stable(commonOutputs) [*8];
    endproperty

    chk_ready_setup: assert property (apbSetup |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_ready_quiet: assert property (!psel |=> !pready)
        else $error("ready without a request");
    chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    chk_reset_dark: assert property ($rose(arst_n) |-> commonOutputs == '0)
        else $error("commons on after reset");
    chk_com_legal: assert property ($onehot0(commonOutputs) || &commonOutputs)
        else $error("bad commons");
    chk_dark_idle: assert property (commonOutputs == '0 |-> segmentOutputs == '0)
        else $error("segments on while dark");
    chk_scan_order: assert property (scanStep)
        else $error("common scan out of order");
    chk_slot_hold: assert property (slotHold)
        else $error("slot too short");
endmodule

bind lcdsd_top lcdsd_top_asserts #(.SEG_COUNT(SEG_COUNT), .COM_COUNT(COM_COUNT)) u_asserts (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .segmentOutputs(segmentOutputs), .commonOutputs(commonOutputs)
);

`default_nettype wire
